// ==== rtl/watchdog_pkg.sv ====
// Constants, carrier types and states of the watchdog with locked mode register.
package watchdog_pkg;

    localparam logic [3:0] MODE_BANK        = 4'hF;
    localparam logic [7:0] MODE_OFFSET      = 8'h0F;
    localparam logic [7:0] MODE_RESET       = 8'h00;
    localparam logic [7:0] READ_BACK_VALUE  = 8'h00;
    localparam int         TAP_LSB          = 0;
    localparam int         HALT_RUN_BIT     = 2;
    localparam int         STOP_RUN_BIT     = 3;
    localparam int         WINDOW_PROC_CYCLES  = 60;
    localparam int         CRYSTAL_PER_PROC    = 2;
    localparam int         WINDOW_CLOCKS       = WINDOW_PROC_CYCLES * CRYSTAL_PER_PROC;
    localparam int         CLOCK_PERIOD_NS  = 50;
    localparam int         RC_PERIOD_NS     = 1000;
    localparam int         RC_DIVIDE        = (RC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int         POR_RC_TICKS     = 64;
    localparam int         TAP0_RC_TICKS    = 128;
    localparam int         TAP1_RC_TICKS    = 256;
    localparam int         TAP2_RC_TICKS    = 512;
    localparam int         TAP3_RC_TICKS    = 1024;
    localparam logic [2:0] SERVICE_FLAGS    = 3'h0;

    typedef struct packed {
        logic       stop_run;
        logic       halt_run;
        logic [1:0] tap;
    } mode_s;

    typedef struct packed {
        logic zero;
        logic sign;
        logic overflow;
    } flags_s;

    typedef enum logic [2:0] {
        WD_IDLE = 3'b001,
        WD_RUN  = 3'b010,
        WD_HOLD = 3'b100
    } wd_state_e;

endpackage

// ==== rtl/watchdog_timer.sv ====
// Watchdog timer with a mode register that locks after a short write window.
`timescale 1ns/1ps
module watchdog_timer
    import watchdog_pkg::*;
#(
    parameter int           TAP0_TICKS = TAP0_RC_TICKS,
    parameter int           TAP1_TICKS = TAP1_RC_TICKS,
    parameter int           TAP2_TICKS = TAP2_RC_TICKS,
    parameter int           TAP3_TICKS = TAP3_RC_TICKS,
    parameter int           POR_TICKS  = POR_RC_TICKS,
    parameter int           RC_DIV     = RC_DIVIDE,
    parameter logic [7:0]   MODE_INIT  = MODE_RESET,
    parameter int           COUNT_W    = 16
)(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       service_exec,
    input  wire logic       instr_exec,
    input  wire logic       halt_mode,
    input  wire logic       stop_mode,
    input  wire logic       stop_recovery,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] register_pointer,
    input  wire logic [7:0] write_data,
    output logic      [7:0] read_data,
    output logic            flags_write,
    output flags_s          flags,
    output logic            core_reset,
    output logic            reset_pin_out,
    output logic            reset_pin_oe
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (TAP0_TICKS < 1 || TAP1_TICKS < 1 || TAP2_TICKS < 1 || TAP3_TICKS < 1 || POR_TICKS < 1 || RC_DIV < 1)
        $error("Tick counts and divider must be at least one.");
    if (TAP0_TICKS >= 2**COUNT_W || TAP1_TICKS >= 2**COUNT_W || TAP2_TICKS >= 2**COUNT_W
        || TAP3_TICKS >= 2**COUNT_W || POR_TICKS >= 2**COUNT_W || RC_DIV >= 2**COUNT_W)
        $error("Counter width too small for the tick counts.");

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wd_state_e          state;
    mode_s              mode;
    logic [COUNT_W-1:0] rc_div_count;
    logic               rc_tick;
    logic [COUNT_W-1:0] wd_count;
    logic [COUNT_W-1:0] por_count;
    logic [COUNT_W-1:0] terminal;
    logic [7:0]         win_count;
    logic               win_started;
    logic               locked;
    logic               mode_hit;
    logic               count_en;
    logic               timeout;
    logic               por_done;
    logic               restart;

    // ------------------------------------------------------------
    // RC oscillator tick and decoding
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rc_div_count <= '0;
            rc_tick      <= 1'b0;
        end
        else if (rc_div_count == COUNT_W'(RC_DIV - 1))
        begin
            rc_div_count <= '0;
            rc_tick      <= 1'b1;
        end
        else
        begin
            rc_div_count <= rc_div_count + 1'b1;
            rc_tick      <= 1'b0;
        end
    end

    assign mode_hit = register_pointer[3:0] == MODE_BANK && reg_addr == MODE_OFFSET;

    always_comb
    begin
        unique case (mode.tap)
            2'd0: terminal = COUNT_W'(TAP0_TICKS);
            2'd1: terminal = COUNT_W'(TAP1_TICKS);
            2'd2: terminal = COUNT_W'(TAP2_TICKS);
            2'd3: terminal = COUNT_W'(TAP3_TICKS);
        endcase
    end

    assign count_en = state == WD_RUN && rc_tick
                      && !(halt_mode && !mode.halt_run)
                      && !(stop_mode && !mode.stop_run);
    assign timeout  = count_en && !service_exec && wd_count == terminal - 1'b1;
    assign por_done = state == WD_HOLD && rc_tick && por_count == COUNT_W'(POR_TICKS - 1);
    assign restart  = state == WD_HOLD || stop_recovery;

    // ------------------------------------------------------------
    // Watchdog state, count and reset outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state         <= WD_HOLD;
            wd_count      <= '0;
            por_count     <= '0;
            core_reset    <= 1'b1;
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b1;
        end
        else
        begin
            reset_pin_out <= 1'b0;
            unique case (state)
                WD_IDLE:
                begin
                    wd_count <= '0;
                    if (service_exec)
                        state <= WD_RUN;
                end
                WD_RUN:
                begin
                    if (service_exec)
                        wd_count <= '0;
                    else if (timeout)
                    begin
                        state        <= WD_HOLD;
                        wd_count     <= '0;
                        por_count    <= '0;
                        core_reset   <= 1'b1;
                        reset_pin_oe <= 1'b1;
                    end
                    else if (count_en)
                        wd_count <= wd_count + 1'b1;
                end
                WD_HOLD:
                begin
                    if (por_done)
                    begin
                        state        <= WD_IDLE;
                        core_reset   <= 1'b0;
                        reset_pin_oe <= 1'b0;
                    end
                    else if (rc_tick)
                        por_count <= por_count + 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write window and mode register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            win_started <= 1'b0;
            win_count   <= '0;
            locked      <= 1'b0;
        end
        else if (restart)
        begin
            win_started <= 1'b0;
            win_count   <= '0;
            locked      <= 1'b0;
        end
        else if (!win_started)
            win_started <= instr_exec;
        else if (!locked)
        begin
            win_count <= win_count + 1'b1;
            locked    <= win_count == 8'(WINDOW_CLOCKS - 1);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            mode <= mode_s'(MODE_INIT[3:0]);
        else if (state == WD_HOLD)
            mode <= mode_s'(MODE_INIT[3:0]);
        else if (reg_write && mode_hit && !locked)
            mode <= mode_s'(write_data[STOP_RUN_BIT:TAP_LSB]);
    end

    // ------------------------------------------------------------
    // Read answer and condition flags
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            read_data <= 8'h00;
        else if (reg_read && mode_hit)
            read_data <= READ_BACK_VALUE;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            flags_write <= 1'b0;
            flags       <= '0;
        end
        else
        begin
            flags_write <= service_exec && state != WD_HOLD;
            if (service_exec && state != WD_HOLD)
                flags <= flags_s'(SERVICE_FLAGS);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_idle_stays_idle: assert property (state == WD_IDLE && !service_exec |=> state == WD_IDLE)
        else $error("Watchdog left idle without a service instruction.");
    a_service_starts: assert property (state == WD_IDLE && service_exec |=> state == WD_RUN && wd_count == 0)
        else $error("Service instruction did not start the watchdog.");
    a_service_restarts: assert property (state == WD_RUN && service_exec |=> state == WD_RUN && wd_count == 0)
        else $error("Service instruction did not restart the count.");
    a_timeout_resets: assert property (state == WD_RUN && timeout |=> core_reset && reset_pin_oe && !reset_pin_out)
        else $error("Terminal count did not reset the core.");
    a_count_on_tick: assert property (state == WD_RUN && !rc_tick && !service_exec |=> $stable(wd_count))
        else $error("Watchdog counted without an RC tick.");
    a_halt_freezes: assert property (state == WD_RUN && halt_mode && !mode.halt_run && !service_exec
                                     |=> $stable(wd_count))
        else $error("Watchdog counted in halt mode.");
    a_stop_freezes: assert property (state == WD_RUN && stop_mode && !mode.stop_run && !service_exec
                                     |=> $stable(wd_count))
        else $error("Watchdog counted in stop mode.");
    a_window_write: assert property (reg_write && mode_hit && !locked && state != WD_HOLD
                                     |=> mode == $past(write_data[3:0]))
        else $error("Mode write inside the window was lost.");
    a_lock_holds: assert property (locked && !restart |=> $stable(mode))
        else $error("Mode changed after the window closed.");
    a_read_hidden: assert property (reg_read && mode_hit |=> read_data == READ_BACK_VALUE)
        else $error("Mode register contents were readable.");
    a_pin_follows: assert property (reset_pin_oe == core_reset && !reset_pin_out)
        else $error("Reset pin does not follow the core reset.");
    a_flags_update: assert property (service_exec && state != WD_HOLD |=> flags_write)
        else $error("Service instruction did not update the flags.");

    c_service_start: cover property (state == WD_IDLE && service_exec ##1 state == WD_RUN);
    c_timeout: cover property (state == WD_RUN ##1 state == WD_HOLD);
    c_window_lock: cover property (!locked ##1 locked);
    c_blocked_write: cover property (locked && reg_write && mode_hit);

endmodule

// ==== test/core_model.sv ====
// Model of the core that executes instructions toward the watchdog.
`timescale 1ns/1ps
module core_model
(
    input  wire logic       clock,
    input  wire logic       core_reset,
    input  wire logic [1:0] request,
    output logic            service_exec,
    output logic            instr_exec
);
    // The core issues nothing while it is held in reset.
    always @(negedge clock)
    begin
        service_exec <= request[1] && !core_reset;
        instr_exec   <= request[0] && !core_reset;
    end
endmodule

// ==== test/watchdog_timer_with_mode_lock_tb.sv ====
// Self-checking bench for the watchdog with locked mode register.
`timescale 1ns/1ps
module watchdog_timer_with_mode_lock_tb;
    import watchdog_pkg::*;
    localparam int RCD = 2;
    int          taps[4] = '{4, 5, 6, 7};
    logic        clock = 0, reset = 1, halt_mode = 0, stop_mode = 0, stop_recovery = 0;
    logic        reg_write = 0, reg_read = 0;
    logic [7:0]  reg_addr = 8'h00, register_pointer = 8'h00, write_data = 8'h00, read_data;
    logic [1:0]  request = 2'b00;
    logic        service_exec, instr_exec, flags_write, core_reset, reset_pin_out, reset_pin_oe;
    flags_s      flags;
    int          errors = 0, cmp_count = 0, n;
    logic [31:0] seed = 32'd85443;
    int          model_tap = 0;
    time         win_start = 0;

    always #25 clock = ~clock;

    core_model u_core_model (.clock(clock), .core_reset(core_reset), .request(request),
        .service_exec(service_exec), .instr_exec(instr_exec));

    watchdog_timer #(.TAP0_TICKS(4), .TAP1_TICKS(5), .TAP2_TICKS(6), .TAP3_TICKS(7),
        .POR_TICKS(3), .RC_DIV(RCD)) u_watchdog_timer (.clock(clock), .reset(reset),
        .service_exec(service_exec), .instr_exec(instr_exec), .halt_mode(halt_mode),
        .stop_mode(stop_mode), .stop_recovery(stop_recovery), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .register_pointer(register_pointer),
        .write_data(write_data), .read_data(read_data), .flags_write(flags_write), .flags(flags),
        .core_reset(core_reset), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic wait_rst(input logic v, input int bound);
        n = 0;
        while (core_reset !== v)
        begin
            @(negedge clock);
            n++;
            if (n > bound)
            begin
                chk(1'b0, "wait ran out");
                complete_run();
            end
        end
        // A watchdog reset puts the model's mode and window back to their reset state.
        if (v)
        begin
            model_tap = MODE_RESET[1:0];
            win_start = 0;
        end
    endtask

    task automatic op(input logic [1:0] r);
        if (r[0] && win_start == 0)
            win_start = $time;
        request <= r;
        @(negedge clock);
        request <= 2'b00;
        @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        register_pointer = p;
        reg_addr = a;
        write_data = d;
        reg_write = 1'b1;
        if (p[3:0] == MODE_BANK && a == MODE_OFFSET
            && (win_start == 0 || $time - win_start < WINDOW_CLOCKS * CLOCK_PERIOD_NS))
            model_tap = d[1:0];
        @(negedge clock);
        reg_write = 1'b0;
        @(negedge clock);
    endtask

    task automatic expect_timeout;
        int tap;
        tap = model_tap;
        op(2'b10);
        chk(flags_write === 1'b1 && flags === SERVICE_FLAGS, "service flags");
        wait_rst(1'b1, 40);
        chk(n + 1 >= taps[tap] * RCD - RCD && n + 1 <= taps[tap] * RCD + RCD + 3, "timeout length");
        chk(reset_pin_oe === 1'b1 && reset_pin_out === 1'b0, "reset pin");
        wait_rst(1'b0, 40);
        chk(n >= 2 * RCD && n <= 4 * RCD + 2, "hold length");
        $display("test done: timeout with tap %0d", tap);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        chk(core_reset === 1'b1 && reset_pin_oe === 1'b1, "power-on hold");
        wait_rst(1'b0, 50);
        wr(8'h0F, 8'h0F, 8'hFF);
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        chk(read_data === READ_BACK_VALUE, "mode read back");
        repeat (60) @(negedge clock);
        chk(core_reset === 1'b0, "idle watchdog fired");
        $display("test done: power-on hold and idle");
        for (int t = 0; t < 4; t++)
        begin
            op(2'b01);
            seed = xs(seed);
            wr(8'h0F, 8'h0F, {seed[7:4], 2'b00, t[1:0]});
            wr(8'h0E, 8'h0F, seed[15:8]);
            wr(8'h0F, 8'h0E, seed[23:16]);
            expect_timeout();
        end
        op(2'b10);
        repeat (8)
        begin
            repeat (3) @(negedge clock);
            op(2'b10);
            chk(core_reset === 1'b0, "refresh missed");
        end
        expect_timeout();
        op(2'b01);
        repeat (125) @(negedge clock);
        wr(8'h0F, 8'h0F, 8'h03);
        expect_timeout();
        op(2'b01);
        repeat (125) @(negedge clock);
        stop_recovery = 1'b1;
        win_start = 0;
        @(negedge clock);
        stop_recovery = 1'b0;
        wr(8'h0F, 8'h0F, 8'h03);
        expect_timeout();
        halt_mode = 1'b1;
        op(2'b10);
        repeat (40) @(negedge clock);
        chk(core_reset === 1'b0, "counted in halt");
        halt_mode = 1'b0;
        stop_mode = 1'b1;
        repeat (40) @(negedge clock);
        chk(core_reset === 1'b0, "counted in stop");
        stop_mode = 1'b0;
        wait_rst(1'b1, 40);
        wait_rst(1'b0, 40);
        $display("test done: halt and stop gating");
        op(2'b01);
        wr(8'h0F, 8'h0F, 8'h04);
        halt_mode = 1'b1;
        expect_timeout();
        halt_mode = 1'b0;
        op(2'b01);
        wr(8'h0F, 8'h0F, 8'h08);
        stop_mode = 1'b1;
        expect_timeout();
        stop_mode = 1'b0;
        complete_run();
    end
endmodule
